// ===== pgseq_top.sv
/*
 * power good sequencer: two switcher channels, linear monitor, delay timer,
 * open-drain power good output.
 * assumes comparator pins asynchronous; clock_in is the switching clock.
 */
// Notes on behaviour
// - idle until supply power-on trip passes
// - output ramps while ramp 1.0-1.6 V
// - soft-start done when ramp reaches 3.2 V
// - timer starts: ramps done, outputs in window
// - switcher window 90-110 percent, linear 75
// - delay is 0.065 s over MHz
// - timer expiry releases power good pull-down
// - any failed condition drives line low
// - full new delay after violation clears
// - delay from switching clock only
// - low prebias: fets off until ramp passes
// - high prebias: switching off until ramp ends
// - above overvoltage: protection at ramp end
// - channels sequence independently
// - linear has no ramp, monitored after supply
module pgseq_top #(
    parameter int DELAY_CYCLES = pgseq_pkg::PGSEQ_DELAY_CYCLES
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic supply_por_in, // supply above rising trip
    input wire logic [1:0] ramp_above_out_in, // per channel ramp above output
    input wire logic [1:0] ramp_at_full_in, // per channel ramp past 1.6 V
    input wire logic [1:0] ramp_done_in, // per channel ramp above 3.2 V
    input wire logic [1:0] out_above_target_in, // per channel output above final
    input wire logic [1:0] out_above_ovp_in, // per channel output above ovp level
    input wire logic [1:0] feedback_input_low_ok_in, // feedback above 90 percent
    input wire logic [1:0] feedback_input_high_ok_in, // feedback below 110 percent
    input wire logic linear_low_ok_in, // linear feedback above 75 percent
    input wire logic linear_supply_ok_in, // linear input supply risen
    input wire logic power_good_output_in, // sensed level of power good line
    output logic power_good_output_out, // always low when driven
    output logic power_good_output_oe_out, // pull-down active
    output logic [1:0] switch_enable_out, // per channel fets allowed
    output logic [1:0] overvoltage_protection_out // per channel protection
);
    import pgseq_pkg::*;

    // number of comparator bits synchronised
    localparam int NSYNC = 17;

    // whole module state
    typedef struct packed {
        logic [NSYNC-1:0] sync1; // first synchroniser stage
        logic [NSYNC-1:0] sync2; // second synchroniser stage
        logic [PGSEQ_CNT_W-1:0] cnt; // delay counter
        logic good; // power good released
    } pgseq_top_t;

    pgseq_top_t s_reg;
    pgseq_top_t s_next;

    // synchronised views
    logic por_s;
    logic lin_low_s;
    logic lin_sup_s;
    logic [1:0] above_s;
    logic [1:0] full_s;
    logic [1:0] done_s;
    logic [1:0] tgt_s;
    logic [1:0] ovp_s;
    logic [1:0] lo_s;
    logic [1:0] hi_s;
    logic [1:0] ch_done;
    logic qualify;

    assign {por_s, lin_low_s, lin_sup_s, above_s, full_s, done_s, tgt_s, ovp_s, lo_s, hi_s}
        = s_reg.sync2;

    // independent channel instances
    genvar g;
    generate
        for (g = 0; g < PGSEQ_CHANNELS; g++) begin : gen_ch
            pgseq_channel u_ch (
                .clock_in(clock_in),
                .rstn_in(rstn_in),
                .run_in(por_s),
                .ramp_above_out_in(above_s[g]),
                .ramp_at_full_in(full_s[g]),
                .ramp_done_in(done_s[g]),
                .out_above_target_in(tgt_s[g]),
                .out_above_ovp_in(ovp_s[g]),
                .switch_enable_out(switch_enable_out[g]),
                .ramp_done_out(ch_done[g]),
                .overvoltage_protection_out(overvoltage_protection_out[g])
            );
        end
    endgenerate

    // all conditions: ramps done, windows met, linear above floor
    assign qualify = por_s && (&ch_done) && (&lo_s) && (&hi_s) && lin_sup_s && lin_low_s;

    // next state: synchronisers and delay timer
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = {supply_por_in, linear_low_ok_in, linear_supply_ok_in,
            ramp_above_out_in, ramp_at_full_in, ramp_done_in, out_above_target_in,
            out_above_ovp_in, feedback_input_low_ok_in, feedback_input_high_ok_in};
        s_next.sync2 = s_reg.sync1;
        if (!qualify) begin // clear and pull low at once
            s_next.cnt = '0;
            s_next.good = 1'b0;
        end else if (!s_reg.good) begin
            // counts switching clock cycles only
            if (s_reg.cnt >= PGSEQ_CNT_W'(DELAY_CYCLES - 1)) begin
                s_next.good = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + PGSEQ_CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // open drain: pull low unless released; low also the instant conditions fail
    assign power_good_output_out = 1'b0;
    assign power_good_output_oe_out = !(s_reg.good && qualify);

    a_delay_expire: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (qualify && s_reg.cnt == PGSEQ_CNT_W'(DELAY_CYCLES - 1) && !s_reg.good)
        ##1 qualify |-> !power_good_output_oe_out)
        else $error("power good not released at expiry");
    a_fail_low: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (!por_s || !(&lo_s) || !(&hi_s) || !lin_low_s || !lin_sup_s) |-> power_good_output_oe_out)
        else $error("power good high with failed condition");
    a_restart_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !qualify |=> (s_reg.cnt == '0 && !s_reg.good))
        else $error("timer not cleared on violation");
    a_count_step: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (qualify && !s_reg.good && s_reg.cnt < PGSEQ_CNT_W'(DELAY_CYCLES - 1))
        ##1 qualify |-> s_reg.cnt == $past(s_reg.cnt) + PGSEQ_CNT_W'(1))
        else $error("delay counter skipped");
    a_not_early: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (!power_good_output_oe_out) |-> (s_reg.good && &ch_done
         && s_reg.cnt == PGSEQ_CNT_W'(DELAY_CYCLES - 1)))
        else $error("power good before ramps done");
endmodule : pgseq_top

// ===== pgseq_pkg.sv
/*
 * package for the power good sequencer: timing counts and channel states.
 * assumes one 50 MHz system clock that stands in for the switching clock.
 */
package pgseq_pkg;
    // power good delay, cycles of the switching clock (0.065 s x 1e6 / MHz)
    localparam int PGSEQ_DELAY_CYCLES = 65000;
    // width of the delay counter
    localparam int PGSEQ_CNT_W = 17;
    // number of switcher channels
    localparam int PGSEQ_CHANNELS = 2;

    // per channel soft-start and prebias state, one-hot
    typedef enum logic [4:0] {
        PGSEQ_CH_IDLE   = 5'h01, // waiting for power-on trip
        PGSEQ_CH_RAMP   = 5'h02, // ramp charging, switching held off
        PGSEQ_CH_REG    = 5'h04, // ramp passed output, regulating
        PGSEQ_CH_DONE   = 5'h08, // ramp complete, regulating
        PGSEQ_CH_OVP    = 5'h10  // overvoltage protection, fets off
    } pgseq_ch_state_t;
endpackage : pgseq_pkg

// ===== pgseq_channel.sv
/*
 * one switcher channel: soft-start tracking and prebias handling.
 * assumes comparator levels already synchronised by the parent.
 */
module pgseq_channel (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic run_in, // power-on trip passed
    input wire logic ramp_above_out_in, // ramp above output level
    input wire logic ramp_at_full_in, // ramp past full-scale point
    input wire logic ramp_done_in, // ramp near end level
    input wire logic out_above_target_in, // output above final value
    input wire logic out_above_ovp_in, // output above overvoltage level
    output logic switch_enable_out, // fets may switch
    output logic ramp_done_out, // soft-start complete
    output logic overvoltage_protection_out // latched overvoltage protection
);
    import pgseq_pkg::*;

    // whole module state
    typedef struct packed {
        pgseq_ch_state_t st;
    } pgseq_ch_t;

    pgseq_ch_t s_reg;
    pgseq_ch_t s_next;

    // next state logic
    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            PGSEQ_CH_IDLE: begin
                if (run_in) begin
                    s_next.st = PGSEQ_CH_RAMP;
                end
            end
            PGSEQ_CH_RAMP: begin
                // fets held off while output prebiased above ramp
                if (ramp_done_in) begin
                    if (out_above_ovp_in) begin
                        s_next.st = PGSEQ_CH_OVP;
                    end else begin // above target: pull down now
                        s_next.st = PGSEQ_CH_DONE;
                    end
                end else if (ramp_above_out_in && !out_above_target_in) begin
                    s_next.st = PGSEQ_CH_REG;
                end
            end
            PGSEQ_CH_REG: begin
                // output follows ramp between 1.0 V and 1.6 V
                if (ramp_done_in) begin
                    s_next.st = out_above_ovp_in ? PGSEQ_CH_OVP : PGSEQ_CH_DONE;
                end
            end
            PGSEQ_CH_DONE: begin
                // stays done; window faults hold power good low in the parent, unlatched
                s_next.st = PGSEQ_CH_DONE;
            end
            PGSEQ_CH_OVP: begin
                // latched until power cycle
                s_next.st = PGSEQ_CH_OVP;
            end
            default: begin
                s_next.st = PGSEQ_CH_IDLE;
            end
        endcase
        if (!run_in) begin // lost supply returns to idle
            s_next.st = PGSEQ_CH_IDLE;
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            s_reg <= '{st: PGSEQ_CH_IDLE};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs decoded from state
    assign switch_enable_out = (s_reg.st == PGSEQ_CH_REG) || (s_reg.st == PGSEQ_CH_DONE);
    assign ramp_done_out = (s_reg.st == PGSEQ_CH_DONE);
    assign overvoltage_protection_out = (s_reg.st == PGSEQ_CH_OVP);

    a_prebias_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
        (s_reg.st == PGSEQ_CH_RAMP && !ramp_above_out_in && !ramp_done_in) |=> !switch_enable_out)
        else $error("switching during held ramp");
    a_ovp_fets_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ($past(s_reg.st) == PGSEQ_CH_RAMP && $past(ramp_done_in) && $past(out_above_ovp_in)
         && $past(run_in) && run_in) |-> (overvoltage_protection_out && !switch_enable_out))
        else $error("overvoltage not entered at ramp end");
    a_high_prebias: assert property (@(posedge clock_in) disable iff (!rstn_in)
        ($past(s_reg.st) == PGSEQ_CH_RAMP && $past(out_above_target_in)
         && !$past(ramp_done_in)) |-> !switch_enable_out)
        else $error("switching before ramp end with high prebias");
    a_idle_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
        !$past(run_in) |-> (s_reg.st == PGSEQ_CH_IDLE))
        else $error("channel left idle without supply");
endmodule : pgseq_channel

// ===== pgseq_supervisor.sv
/*
 * supervisor model: senses the open-drain power good line.
 * assumes the device only pulls the line low; an external pull-up raises it.
 */
module pgseq_supervisor (
    input wire logic pull_down_in, // device pull-down active
    output logic line_out // resolved line level seen by the supervisor
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins whenever the device lets go of the line
    assign line_out = pull_down_in ? 1'b0 : 1'b1;
endmodule : pgseq_supervisor

// ===== tb.sv
/*
 * testbench for the power good sequencer: startup, prebias, faults, overvoltage.
 * assumes pgseq_top with a short delay count and the supervisor model beside it.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pgseq_pkg::*;
    localparam int DLY = 20; // shortened delay count
    logic clk = 1'b0, rstn = 1'b0, por = 1'b0, lin_lo = 1'b0, lin_sup = 1'b0;
    logic [1:0] ra = 2'h0, rf = 2'h0, rd = 2'h0, oat = 2'h0, oao = 2'h0;
    logic [1:0] flo = 2'h0, fhi = 2'h0, se, overvoltage_protection;
    logic pg_d, oe, pg_line;
    int n_mismatch = 0, n_compared = 0, cnt, k;
    logic [15:0] seed = 16'hD156; // xorshift state
    // clock, 50 MHz
    initial forever #10 clk = ~clk;
    pgseq_top #(.DELAY_CYCLES(DLY)) dut (.clock_in(clk), .rstn_in(rstn),
        .supply_por_in(por), .ramp_above_out_in(ra), .ramp_at_full_in(rf),
        .ramp_done_in(rd), .out_above_target_in(oat), .out_above_ovp_in(oao),
        .feedback_input_low_ok_in(flo), .feedback_input_high_ok_in(fhi),
        .linear_low_ok_in(lin_lo), .linear_supply_ok_in(lin_sup),
        .power_good_output_in(pg_line), .power_good_output_out(pg_d),
        .power_good_output_oe_out(oe), .switch_enable_out(se),
        .overvoltage_protection_out(overvoltage_protection));
    pgseq_supervisor sup (.pull_down_in(oe), .line_out(pg_line));
    // next random value
    function automatic logic [15:0] xorshift(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction : xorshift
    // one comparison of a small value
    task automatic check_bit(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit
    // advance n edges, then drive just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // all window and linear conditions from one vector
    task automatic set_conds(input logic [5:0] v);
        {lin_sup, lin_lo, fhi, flo} = v;
    endtask : set_conds
    // count edges until the pull-down lets go, bounded
    task automatic wait_release(output int c);
        c = 0;
        while (oe === 1'b1 && c < DLY + 10) begin
            step(1);
            c++;
        end
    endtask : wait_release
    // synchronous reset for ten cycles with every input but rf quiet
    task automatic restart;
        rstn = 1'b0;
        por = 1'b0;
        {ra, rd, oat, oao} = 8'h00;
        set_conds(6'h00);
        step(10);
        rstn = 1'b1;
        step(1);
    endtask : restart
    // closing verdict
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog
    initial begin
        #(20 * 6000);
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rf = 2'h3;
        restart();
        check_bit({1'b0, oe}, 2'h1);
        ra = 2'h3; // ramps high but supply trip absent
        step(8);
        check_bit(se, 2'h0);
        check_bit({1'b0, pg_line}, 2'h0);
        por = 1'b1;
        oat = 2'h2; // channel 2 prebiased above target
        step(8);
        check_bit(se, 2'h1);
        check_bit({1'b0, pg_d}, 2'h0);
        set_conds(6'h3F);
        step(8);
        check_bit(se, 2'h1);
        rd = 2'h3;
        wait_release(cnt);
        check_bit({1'b0, cnt == DLY + 3}, 2'h1);
        check_bit(se, 2'h3);
        check_bit({1'b0, pg_line}, 2'h1);
        $display("test startup done");
        for (int i = 0; i < 10; i++) begin
            seed = xorshift(seed);
            k = int'(seed % 16'h0006);
            set_conds(6'h3F ^ (6'h01 << k));
            step(3);
            check_bit({1'b0, oe}, 2'h1);
            step(int'(seed[3:0]));
            set_conds(6'h3F);
            wait_release(cnt);
            check_bit({1'b0, cnt == DLY + 2}, 2'h1);
            check_bit({1'b0, pg_line}, 2'h1);
        end
        $display("test faults done");
        restart();
        por = 1'b1;
        ra = 2'h1; // channel 2 ramp still below its prebiased output
        oat = 2'h1;
        oao = 2'h1; // channel 1 prebiased above overvoltage level
        set_conds(6'h3F);
        step(8);
        check_bit(overvoltage_protection, 2'h0);
        check_bit(se, 2'h0);
        ra = 2'h3;
        step(4);
        check_bit(se, 2'h2);
        rd = 2'h3;
        step(DLY + 10);
        check_bit(overvoltage_protection, 2'h1);
        check_bit(se, 2'h2);
        check_bit({1'b0, pg_line}, 2'h0);
        $display("test overvoltage done");
        tally_and_finish();
    end
endmodule : tb
